// >>> hw/port_a_pin_logic.sv
`timescale 1ns/1ns
// What this block does
// - Output pin follows latch, analog select ignored.
// - Input pin readable; analog select blocks it.
// - Pins 0-3 and 5 reset to analog.
// - Pin 4 resets as digital input.
// - Timer inputs sample pins regardless of direction.
// - Pin 6 may output system clock over four.
// - Oscillator config bit disables pins 6, 7.
// - Bits 6, 7 exist only when pins free.
// - Direction bit one means input, zero output.
// - Writing level or latch register updates latch.
// - Analog bit set means analog, clear digital.
// - Analog pins read zero; analog after reset.
// - Internal oscillator frees pins 6, 7 for I/O.
module port_a_pin_logic #(
  parameter int PIN_COUNT = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe,
  output logic timer0_ext_clock_in,
  output logic timer1_ext_clock_in,
  output logic timer3_gate_in,
  output logic cycle_clock_out
);

  logic [7:0] port_a_output_latch;
  logic [7:0] port_a_direction;
  logic [4:0] analog_select_low;
  logic [2:0] clock_config;
  logic [7:0] pin_sample;
  logic [1:0] divide_count;
  logic [7:0] next_port_a_output_latch;
  logic [7:0] next_port_a_direction;
  logic [4:0] next_analog_select_low;
  logic [2:0] next_clock_config;
  logic [31:0] next_prdata;
  logic [1:0] next_divide_count;
  logic next_cycle_clock_out;
  logic [7:0] analog_pins;
  logic [7:0] digital_ok;
  logic [7:0] pin_level_view;
  logic pins_high_free;
  logic clock_out_active;
  logic setup_phase;
  logic write_access;

  // Known register offsets; anything else earns pslverr.
  function automatic logic addr_mapped(input logic [11:0] a);
    return a == port_a_pkg::OFS_PIN_LEVEL || a == port_a_pkg::OFS_OUT_LATCH
        || a == port_a_pkg::OFS_DIRECTION || a == port_a_pkg::OFS_ANALOG_SEL
        || a == port_a_pkg::OFS_CLOCK_CFG;
  endfunction

  // Spread the five analog select bits onto the pins they own.
  function automatic logic [7:0] spread_analog(input logic [4:0] s);
    return {2'h0, s[port_a_pkg::ANALOG_BIT_OF_PIN5], 1'b0, s[3:0]};
  endfunction

  assign setup_phase = psel && !penable;
  assign write_access = psel && penable && pwrite;
  // The slave never stretches a transfer, since every read is ready early.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);

  // Pins 6 and 7 are free unless the oscillator owns them.
  assign pins_high_free = clock_config[port_a_pkg::CFG_INTERNAL_OSC_BIT]
      || !clock_config[port_a_pkg::CFG_OSC_PIN_BIT];
  assign digital_ok = {{2{pins_high_free}}, 6'h3F};
  assign analog_pins = spread_analog(analog_select_low);
  // Cycle clock replaces port data only when the crystal is not in use.
  assign clock_out_active = clock_config[port_a_pkg::CFG_CLOCK_OUT_BIT]
      && pins_high_free;

  // Pin level view: analog pins and owned oscillator pins read as zero.
  assign pin_level_view = pin_sample & ~analog_pins & digital_ok;

  // Pad drive: a clear direction bit drives the latch, analog or not, on pins the oscillator leaves free; clock out takes pin 6.
  always_comb begin
    pin_out = '0;
    pin_oe = '0;
    for (int i = 0; i < 8; i++) begin
      pin_out[i] = port_a_output_latch[i];
      pin_oe[i] = !port_a_direction[i] && digital_ok[i];
    end
    if (clock_out_active) begin
      pin_out[port_a_pkg::PIN_CLOCK_OUT] = cycle_clock_out;
      pin_oe[port_a_pkg::PIN_CLOCK_OUT] = 1'b1;
    end
  end

  // Next values of the software registers and the read data.
  always_comb begin
    next_port_a_output_latch = port_a_output_latch;
    next_port_a_direction = port_a_direction;
    next_analog_select_low = analog_select_low;
    next_clock_config = clock_config;
    next_prdata = prdata;
    if (write_access && pstrb[0]) begin
      unique case (paddr)
        port_a_pkg::OFS_PIN_LEVEL, port_a_pkg::OFS_OUT_LATCH: begin
          next_port_a_output_latch = pwdata[7:0];
        end
        port_a_pkg::OFS_DIRECTION: begin
          next_port_a_direction = pwdata[7:0];
        end
        port_a_pkg::OFS_ANALOG_SEL: begin
          next_analog_select_low = pwdata[4:0];
        end
        port_a_pkg::OFS_CLOCK_CFG: begin
          next_clock_config = pwdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // Read data is captured in the setup cycle so pready can stay high.
    if (setup_phase && !pwrite) begin
      unique case (paddr)
        port_a_pkg::OFS_PIN_LEVEL: begin
          next_prdata = {24'h0, pin_level_view};
        end
        port_a_pkg::OFS_OUT_LATCH: begin
          next_prdata = {24'h0, port_a_output_latch & digital_ok};
        end
        port_a_pkg::OFS_DIRECTION: begin
          next_prdata = {24'h0, port_a_direction & digital_ok};
        end
        port_a_pkg::OFS_ANALOG_SEL: begin
          next_prdata = {27'h0, analog_select_low};
        end
        port_a_pkg::OFS_CLOCK_CFG: begin
          next_prdata = {29'h0, clock_config};
        end
        default: begin
          next_prdata = 32'h0;
        end
      endcase
    end
  end

  // Register the software state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_output_latch <= port_a_pkg::RST_OUT_LATCH;
      port_a_direction <= port_a_pkg::RST_DIRECTION;
      analog_select_low <= port_a_pkg::RST_ANALOG_SEL;
      clock_config <= port_a_pkg::RST_CLOCK_CFG;
      prdata <= 32'h0;
    end else begin
      port_a_output_latch <= next_port_a_output_latch;
      port_a_direction <= next_port_a_direction;
      analog_select_low <= next_analog_select_low;
      clock_config <= next_clock_config;
      prdata <= next_prdata;
    end
  end

  // Next values of the cycle clock divider.
  always_comb begin
    next_divide_count = divide_count + 2'h1;
    next_cycle_clock_out = cycle_clock_out;
    if (divide_count == 2'(port_a_pkg::CYCLE_CLOCK_HALF - 1)
        || divide_count == 2'(port_a_pkg::CYCLE_CLOCK_DIVIDE - 1)) begin
      next_cycle_clock_out = !cycle_clock_out;
    end
  end

  // Pins are sampled every cycle; timer taps ignore direction and analog.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sample <= 8'h00;
      divide_count <= 2'h0;
      cycle_clock_out <= 1'b0;
      timer0_ext_clock_in <= 1'b0;
      timer1_ext_clock_in <= 1'b0;
      timer3_gate_in <= 1'b0;
    end else begin
      pin_sample <= pin_in[7:0];
      divide_count <= next_divide_count;
      cycle_clock_out <= next_cycle_clock_out;
      timer0_ext_clock_in <= pin_in[port_a_pkg::PIN_TIMER0_CLK];
      timer1_ext_clock_in <= pin_in[port_a_pkg::PIN_TIMER1_CLK];
      timer3_gate_in <= pin_in[port_a_pkg::PIN_TIMER1_CLK];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Output pin 0 shows the latch whatever the analog select says.
  property p_out_follows_latch;
    !port_a_direction[0] && analog_select_low[0]
        |-> pin_oe[0] && pin_out[0] == port_a_output_latch[0];
  endproperty
  a_out_follows_latch: assert property (p_out_follows_latch)
    else $error("Output pin 0 does not follow its latch.");

  // A pin-level read returns the sampled pins, analog ones as zero.
  property p_level_read;
    setup_phase && !pwrite && paddr == port_a_pkg::OFS_PIN_LEVEL
        |=> prdata[7:0] == ($past(pin_sample) & ~$past(analog_pins)
            & $past(digital_ok));
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("Pin level read returned wrong data.");

  // After reset the converter-shared pins are analog and undriven.
  property p_reset_analog;
    $rose(presetn) |-> analog_pins == port_a_pkg::ANALOG_PIN_MASK
        && pin_oe == 8'h00;
  endproperty
  a_reset_analog: assert property (p_reset_analog)
    else $error("Pins are not analog inputs after reset.");

  property p_pin4_input;
    $rose(presetn) |-> !pin_oe[4] && !analog_pins[4];
  endproperty
  a_pin4_input: assert property (p_pin4_input)
    else $error("Pin 4 is not a digital input after reset.");

  // Attempts start only once reset is seen released, so the edge that
  // lets reset go never compares a tap against a value held in reset.
  property p_timer_tap;
    presetn |-> ##1 timer0_ext_clock_in == $past(pin_in[4])
        && timer1_ext_clock_in == $past(pin_in[5])
        && timer3_gate_in == $past(pin_in[5]);
  endproperty
  a_timer_tap: assert property (p_timer_tap)
    else $error("Timer taps do not sample the pins.");

  // The cycle clock has a period of four system clocks.
  property p_cycle_clock;
    presetn |-> ##2 cycle_clock_out != $past(cycle_clock_out, 2);
  endproperty
  a_cycle_clock: assert property (p_cycle_clock)
    else $error("Cycle clock is not the system clock over four.");

  property p_osc_pins_off;
    clock_config == 3'h1 |-> pin_oe[7:6] == 2'h0;
  endproperty
  a_osc_pins_off: assert property (p_osc_pins_off)
    else $error("Oscillator pins are still driven.");

  property p_internal_frees;
    clock_config[1] && !port_a_direction[7] |-> pin_oe[7];
  endproperty
  a_internal_frees: assert property (p_internal_frees)
    else $error("Pin 7 not freed in internal oscillator mode.");

  property p_write_latch;
    write_access && pstrb[0] && (paddr == port_a_pkg::OFS_PIN_LEVEL
        || paddr == port_a_pkg::OFS_OUT_LATCH)
        |=> port_a_output_latch == $past(pwdata[7:0]);
  endproperty
  a_write_latch: assert property (p_write_latch)
    else $error("Latch not updated by a port write.");

  property p_analog_zero;
    write_access && pstrb[0] && paddr == port_a_pkg::OFS_ANALOG_SEL
        && pwdata[4:0] == 5'h00 |=> analog_pins == 8'h00;
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("Zero analog select left a pin analog.");

  c_write_dir: cover property (write_access
      && paddr == port_a_pkg::OFS_DIRECTION);
  c_clock_out: cover property (clock_out_active && pin_oe[6]);
  c_level_read: cover property (setup_phase && !pwrite
      && paddr == port_a_pkg::OFS_PIN_LEVEL);
  c_bad_addr: cover property (pslverr);

endmodule

// >>> hw/port_a_pkg.sv
package port_a_pkg;

  // Register byte offsets on the APB side.
  localparam logic [11:0] OFS_PIN_LEVEL = 12'h000;
  localparam logic [11:0] OFS_OUT_LATCH = 12'h004;
  localparam logic [11:0] OFS_DIRECTION = 12'h008;
  localparam logic [11:0] OFS_ANALOG_SEL = 12'h00C;
  localparam logic [11:0] OFS_CLOCK_CFG = 12'h010;

  // Values after power-on reset.
  localparam logic [7:0] RST_OUT_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [4:0] RST_ANALOG_SEL = 5'h1F;
  localparam logic [2:0] RST_CLOCK_CFG = 3'h0;

  // Fields of the clock configuration register.
  localparam int CFG_OSC_PIN_BIT = 0;
  localparam int CFG_INTERNAL_OSC_BIT = 1;
  localparam int CFG_CLOCK_OUT_BIT = 2;

  // Pin positions with a special role.
  localparam int PIN_TIMER0_CLK = 4;
  localparam int PIN_TIMER1_CLK = 5;
  localparam int PIN_CLOCK_OUT = 6;
  localparam int PIN_OSC_IN = 7;

  // Which analog select bit owns each converter-shared pin.
  localparam logic [7:0] ANALOG_PIN_MASK = 8'h2F;
  localparam int ANALOG_BIT_OF_PIN5 = 4;

  // Divider that turns the system clock into the cycle clock.
  localparam int CYCLE_CLOCK_DIVIDE = 4;
  localparam int CYCLE_CLOCK_HALF = CYCLE_CLOCK_DIVIDE / 2;

endpackage

// >>> verification/port_a_board.sv
`timescale 1ns/1ns
// Board side of the eight pads. A pad that the device drives follows it;
// any other pad carries the level that the board itself puts on it.
module port_a_board (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] board_level,
  output logic [7:0] pin_in
);
  // Resolved pad level, fed back to the device as its input.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] pin_in, pin_out, pin_oe, bl, v, w;
  logic timer0_ext_clock_in, timer1_ext_clock_in, timer3_gate_in;
  logic cycle_clock_out, s0;
  logic [32:0] expq[$];
  int n_mismatch, comparisons, seed;

  port_a_pin_logic #(.PIN_COUNT(8)) port_a_pin_logic_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe, .timer0_ext_clock_in,
    .timer1_ext_clock_in, .timer3_gate_in, .cycle_clock_out);
  port_a_board port_a_board_i (.pin_out, .pin_oe, .board_level(bl),
    .pin_in);

  // Free-running system clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; a read files its expected answer for the monitor.
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
    input logic [32:0] exp);
    if (!wr) expq.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h0, e});
  endtask

  // Read answers are taken at the completing edge, oldest note first.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      check({pslverr, prdata}, expq.size() ? expq.pop_front() : 'x);
    end
  end

  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hung handshake ends the run here; the whole test needs ~12 us.
  initial begin
    #200000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    seed = 29203;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    bl = $random(seed);
    v = $random(seed);
    w = $random(seed);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    check(pin_oe, 8'h00);
    @(posedge pclk);
    rd(port_a_pkg::OFS_OUT_LATCH, 8'h00);
    rd(port_a_pkg::OFS_DIRECTION, 8'hFF);
    rd(port_a_pkg::OFS_ANALOG_SEL, 8'h1F);
    rd(port_a_pkg::OFS_PIN_LEVEL, bl & 8'hD0);
    $display("reset test done");
    // Digital setup as in the usual port start-up sequence.
    wr(port_a_pkg::OFS_ANALOG_SEL, 8'h00);
    wr(port_a_pkg::OFS_DIRECTION, 8'hBF);
    @(negedge pclk);
    check(pin_oe, 8'h40);
    @(posedge pclk);
    wr(port_a_pkg::OFS_PIN_LEVEL, v);
    rd(port_a_pkg::OFS_OUT_LATCH, v);
    @(negedge pclk);
    check(pin_out[6], v[6]);
    @(posedge pclk);
    rd(port_a_pkg::OFS_PIN_LEVEL, (bl & 8'hBF) | (v & 8'h40));
    wr(port_a_pkg::OFS_OUT_LATCH, w);
    rd(port_a_pkg::OFS_OUT_LATCH, w);
    $display("direction test done");
    // Analog selection must not disturb outputs, only the read path.
    wr(port_a_pkg::OFS_ANALOG_SEL, 8'h1F);
    wr(port_a_pkg::OFS_DIRECTION, 8'h00);
    @(negedge pclk);
    check(pin_out, w);
    check({timer0_ext_clock_in, timer1_ext_clock_in, timer3_gate_in},
      {w[4], w[5], w[5]});
    @(posedge pclk);
    wr(port_a_pkg::OFS_DIRECTION, 8'hFF);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check({timer0_ext_clock_in, timer1_ext_clock_in, timer3_gate_in},
      {bl[4], bl[5], bl[5]});
    @(posedge pclk);
    rd(port_a_pkg::OFS_PIN_LEVEL, bl & 8'hD0);
    wr(port_a_pkg::OFS_ANALOG_SEL, 8'h10);
    rd(port_a_pkg::OFS_PIN_LEVEL, bl & 8'hDF);
    $display("analog test done");
    // Oscillator ownership of pins 6 and 7, then the cycle clock output.
    // Direction bits 6 and 7 are set so that their masking is visible.
    wr(port_a_pkg::OFS_DIRECTION, 8'hC0);
    wr(port_a_pkg::OFS_CLOCK_CFG, 8'h01);
    @(negedge pclk);
    check(pin_oe, 8'h3F);
    @(posedge pclk);
    rd(port_a_pkg::OFS_DIRECTION, 8'h00);
    rd(port_a_pkg::OFS_OUT_LATCH, w & 8'h3F);
    wr(port_a_pkg::OFS_DIRECTION, 8'h00);
    wr(port_a_pkg::OFS_CLOCK_CFG, 8'h03);
    @(negedge pclk);
    check(pin_oe, 8'hFF);
    @(posedge pclk);
    wr(port_a_pkg::OFS_CLOCK_CFG, 8'h04);
    @(negedge pclk);
    s0 = cycle_clock_out;
    check(pin_out[6], s0);
    repeat (2) @(negedge pclk);
    check(cycle_clock_out, !s0);
    repeat (2) @(negedge pclk);
    check(pin_out[6], s0);
    @(posedge pclk);
    // Clock output asked for while the oscillator owns the pins stays off.
    wr(port_a_pkg::OFS_CLOCK_CFG, 8'h05);
    @(negedge pclk);
    check(pin_oe, 8'h3F);
    @(posedge pclk);
    wr(port_a_pkg::OFS_CLOCK_CFG, 8'h00);
    $display("clock test done");
    // A write without its low strobe and an unmapped read are refused.
    pstrb <= 4'h0;
    wr(port_a_pkg::OFS_OUT_LATCH, ~w);
    pstrb <= 4'hF;
    rd(port_a_pkg::OFS_OUT_LATCH, w);
    apb(1'b0, 12'h014, 8'h00, {1'b1, 32'h0});
    $display("refusal test done");
    finish_test;
  end
endmodule
